//--- logic/tx_fmt_pkg.sv
// How it works
// - Delay 0 sends a slot's first bit in the cycle after the frame-sync cycle, 1h one cycle later, 2h two later; 3h is reserved.
// - The two-bit sync-to-data delay sits in bits 17 to 16 of the format register, and 3h is not a valid setting.
// - Order bit 1 reverses the word so it goes out MSB first; order bit 0 leaves it and sends LSB first.
// - Mask-zero positions get a pad: code 0 pads zero, 1h pads one, 2h copies a chosen bit; 3h is reserved.
// - With pad code 2h, the five-bit field in bits 12 to 8 picks which written bit, 0 to 31, is copied.
// - Slot-size codes 3h, 5h, 7h, 9h, Bh, Dh, Fh give 8, 12, 16, 20, 24, 28, 32 bits; the rest are reserved.
// - With the source select at 0 only the data port may write the serializer buffer; bus writes to it are dropped.
// - With the source select at 1 only the bus may write the serializer buffer; data-port writes are dropped.
// - The word is rotated right by four times the three-bit rotation code, 0 to 28 positions.
// - Bits 31 to 18 of the format register read as zero and ignore writes.
// - Every format field resets to zero and every non-reserved field is readable and writable.
// - The 32-bit mask acts before rotation and reversal: mask 0 puts the pad value in, mask 1 passes the bit.
package tx_fmt_pkg;
	localparam logic [3:0] ADDR_FORMAT = 4'h0;
	localparam logic [3:0] ADDR_MASK = 4'h4;
	localparam logic [3:0] ADDR_BUFFER = 4'h8;
	localparam logic [3:0] ADDR_STATUS = 4'hc;
	localparam int FMT_WIDTH = 18;
	localparam logic [FMT_WIDTH-1:0] FORMAT_RESET = 18'h00000;
	localparam logic [31:0] MASK_RESET = 32'h00000000;
	localparam int POS_ROT = 0;
	localparam int POS_SRC = 3;
	localparam int POS_SLOT = 4;
	localparam int POS_PBIT = 8;
	localparam int POS_PAD = 13;
	localparam int POS_ORDER = 15;
	localparam int POS_DLY = 16;
	localparam int POS_BUSY = 0;
	localparam int POS_OVERRUN = 1;
	localparam logic [1:0] PAD_ZERO = 2'h0;
	localparam logic [1:0] PAD_ONE = 2'h1;
	localparam logic [1:0] PAD_COPY = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int PAYLOAD_W = 38;
	typedef enum logic [2:0] {
		SER_IDLE = 3'b001,
		SER_DELAY = 3'b010,
		SER_SHIFT = 3'b100
	} ser_state_t;
endpackage : tx_fmt_pkg

//--- logic/fmt_if.sv
interface fmt_if;
	logic [31:0] data;
	logic [31:0] mask;
	logic [1:0] pad_sel;
	logic [4:0] pad_bit;
	logic [2:0] rot;
	logic order;
	logic [31:0] result;
	modport cfg (output data, output mask, output pad_sel, output pad_bit, output rot, output order, input result);
	modport unit (input data, input mask, input pad_sel, input pad_bit, input rot, input order, output result);
endinterface : fmt_if

//--- logic/word_formatter.sv
module word_formatter
	import tx_fmt_pkg::*;
(
	fmt_if.unit f
);
	logic pad_val;
	logic [31:0] padded;
	logic [63:0] doubled;
	logic [63:0] shifted;
	logic [31:0] rotated;
	logic [31:0] reversed;

	assign pad_val = (f.pad_sel == PAD_ONE) ? 1'b1 : (f.pad_sel == PAD_COPY) ? f.data[f.pad_bit] : 1'b0;
	assign padded = (f.data & f.mask) | (~f.mask & {32{pad_val}});
	assign doubled = {padded, padded};
	assign shifted = doubled >> {f.rot, 2'b00};
	assign rotated = shifted[31:0];

	genvar i;
	generate
		for (i = 0; i < 32; i++) begin : g_rev
			assign reversed[i] = rotated[31-i];
		end
	endgenerate

	assign f.result = f.order ? reversed : rotated;
endmodule : word_formatter

//--- logic/slot_serializer.sv
module slot_serializer
	import tx_fmt_pkg::*;
(
	input wire logic tx_bit_clock,
	input wire logic resetn,
	input wire logic tx_frame_sync,
	input wire logic req_toggle,
	input wire logic [PAYLOAD_W-1:0] payload,
	output logic ack_toggle,
	output logic serial_data_pin_o,
	output logic serial_data_pin_oe
);
	logic req_s1_q, req_s2_q, ack_q;
	logic fs_prev_q;
	logic [31:0] word_q, shift_q;
	logic [1:0] dly_q, dcnt_q;
	logic [3:0] slot_q;
	logic [5:0] cnt_q;
	logic dout_q, oe_q;
	ser_state_t state_q;
	logic new_word, fs_start;
	logic [5:0] slot_bits;

	// The frame sync is produced on this same clock, so it is sampled without a synchroniser.
	assign fs_start = tx_frame_sync & ~fs_prev_q;
	assign new_word = req_s2_q ^ ack_q;
	assign slot_bits = {1'b0, slot_q, 1'b0} + 6'h02;
	assign ack_toggle = ack_q;
	assign serial_data_pin_o = dout_q;
	assign serial_data_pin_oe = oe_q;

	always_ff @(posedge tx_bit_clock or negedge resetn) begin
		if (!resetn) begin
			req_s1_q <= 1'b0;
			req_s2_q <= 1'b0;
			ack_q <= 1'b0;
			fs_prev_q <= 1'b0;
			word_q <= 32'h00000000;
			dly_q <= 2'h0;
			slot_q <= 4'h0;
		end else begin
			req_s1_q <= req_toggle;
			req_s2_q <= req_s1_q;
			fs_prev_q <= tx_frame_sync;
			if (new_word) begin
				word_q <= payload[31:0];
				dly_q <= payload[33:32];
				slot_q <= payload[37:34];
				ack_q <= req_s2_q;
			end
		end
	end

	// A slot starts on the rising edge of the frame sync and restarts if a new one comes early.
	always_ff @(posedge tx_bit_clock or negedge resetn) begin
		if (!resetn) begin
			state_q <= SER_IDLE;
			shift_q <= 32'h00000000;
			cnt_q <= 6'h00;
			dcnt_q <= 2'h0;
			dout_q <= 1'b0;
			oe_q <= 1'b0;
		end else if (fs_start && dly_q == 2'h0) begin
			state_q <= SER_SHIFT;
			dout_q <= word_q[0];
			oe_q <= 1'b1;
			shift_q <= word_q >> 1;
			cnt_q <= slot_bits - 6'h01;
		end else if (fs_start) begin
			state_q <= SER_DELAY;
			dcnt_q <= dly_q - 2'h1;
			shift_q <= word_q;
			oe_q <= 1'b0;
			dout_q <= 1'b0;
		end else begin
			case (state_q)
				SER_IDLE: begin
					oe_q <= 1'b0;
				end
				SER_DELAY: begin
					if (dcnt_q == 2'h0) begin
						state_q <= SER_SHIFT;
						dout_q <= shift_q[0];
						oe_q <= 1'b1;
						shift_q <= shift_q >> 1;
						cnt_q <= slot_bits - 6'h01;
					end else begin
						dcnt_q <= dcnt_q - 2'h1;
					end
				end
				SER_SHIFT: begin
					if (cnt_q == 6'h00) begin
						state_q <= SER_IDLE;
						oe_q <= 1'b0;
						dout_q <= 1'b0;
					end else begin
						dout_q <= shift_q[0];
						shift_q <= shift_q >> 1;
						cnt_q <= cnt_q - 6'h01;
					end
				end
				default: begin
					state_q <= SER_IDLE;
					oe_q <= 1'b0;
				end
			endcase
		end
	end
endmodule : slot_serializer

//--- logic/audio_tx_bitstream_formatter.sv
module audio_tx_bitstream_formatter
	import tx_fmt_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic bulk_data_port_wr,
	input wire logic [31:0] bulk_data_port_data,
	input wire logic tx_bit_clock,
	input wire logic tx_frame_sync,
	output logic serial_data_pin_o,
	output logic serial_data_pin_oe
);
	logic [FMT_WIDTH-1:0] format_q;
	logic [31:0] mask_q;
	logic [31:0] last_word_q;
	logic overrun_q;
	logic aw_hold_q, w_hold_q;
	logic [3:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic req_q, ack_s1_q, ack_s2_q;
	logic [PAYLOAD_W-1:0] payload_q;
	logic ser_ack;

	logic aw_take, w_take, ar_take, wr_fire;
	logic aw_hold_d, w_hold_d, bvalid_d, rvalid_d;
	logic [31:0] strobe_bits;
	logic wr_format, wr_mask, wr_buffer, wr_status, wr_mapped;
	logic src_bus;
	logic bus_accept, port_accept, buf_accept, busy;
	logic [31:0] source_word;
	logic [31:0] merged_word;
	logic [31:0] format_word;
	logic [31:0] format_merge, mask_merge;
	logic [31:0] status_word;
	logic [31:0] read_word;
	logic rd_mapped;
	logic [3:0] rd_addr;

	fmt_if fmt ();

	// Write channel: address and data are taken independently, the write happens once both are held.
	assign aw_take = s_axi_awvalid & awready_q;
	assign w_take = s_axi_wvalid & wready_q;
	assign wr_fire = aw_hold_q & w_hold_q;
	assign aw_hold_d = (aw_hold_q | aw_take) & ~wr_fire;
	assign w_hold_d = (w_hold_q | w_take) & ~wr_fire;
	assign bvalid_d = wr_fire | (bvalid_q & ~s_axi_bready);
	assign ar_take = s_axi_arvalid & arready_q;
	assign rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);

	genvar b;
	generate
		for (b = 0; b < 4; b++) begin : g_strb
			assign strobe_bits[b*8 +: 8] = {8{wstrb_q[b]}};
		end
	endgenerate

	assign wr_format = wr_fire & (awaddr_q == ADDR_FORMAT);
	assign wr_mask = wr_fire & (awaddr_q == ADDR_MASK);
	assign wr_buffer = wr_fire & (awaddr_q == ADDR_BUFFER);
	assign wr_status = wr_fire & (awaddr_q == ADDR_STATUS);
	assign wr_mapped = wr_format | wr_mask | wr_buffer | wr_status;

	assign format_word = {14'h0000, format_q};
	assign format_merge = (format_word & ~strobe_bits) | (wdata_q & strobe_bits);
	assign mask_merge = (mask_q & ~strobe_bits) | (wdata_q & strobe_bits);
	assign merged_word = (last_word_q & ~strobe_bits) | (wdata_q & strobe_bits);

	// Only one write source is live at a time; the other one is silently dropped.
	assign src_bus = format_q[POS_SRC];
	assign bus_accept = wr_buffer & src_bus;
	assign port_accept = bulk_data_port_wr & ~src_bus;
	assign buf_accept = bus_accept | port_accept;
	assign source_word = src_bus ? merged_word : bulk_data_port_data;
	assign busy = req_q ^ ack_s2_q;

	assign fmt.data = source_word;
	assign fmt.mask = mask_q;
	assign fmt.pad_sel = format_q[POS_PAD +: 2];
	assign fmt.pad_bit = format_q[POS_PBIT +: 5];
	assign fmt.rot = format_q[POS_ROT +: 3];
	assign fmt.order = format_q[POS_ORDER];

	word_formatter u_formatter (
		.f(fmt)
	);

	assign status_word = {30'h00000000, overrun_q, busy};
	// The two low address bits are ignored, as on the write side.
	assign rd_addr = {s_axi_araddr[3:2], 2'b00};
	assign rd_mapped = (rd_addr == ADDR_FORMAT) | (rd_addr == ADDR_MASK) |
		(rd_addr == ADDR_BUFFER) | (rd_addr == ADDR_STATUS);
	assign read_word = (rd_addr == ADDR_FORMAT) ? format_word :
		(rd_addr == ADDR_MASK) ? mask_q :
		(rd_addr == ADDR_BUFFER) ? last_word_q :
		(rd_addr == ADDR_STATUS) ? status_word : 32'h00000000;

	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= 4'h0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else begin
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			awready_q <= ~aw_hold_d & ~bvalid_d;
			wready_q <= ~w_hold_d & ~bvalid_d;
			bvalid_q <= bvalid_d;
			if (aw_take) begin
				awaddr_q <= {s_axi_awaddr[3:2], 2'b00};
			end
			if (w_take) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_fire) begin
				bresp_q <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= RESP_OKAY;
		end else begin
			arready_q <= ~rvalid_d;
			rvalid_q <= rvalid_d;
			if (ar_take) begin
				rdata_q <= read_word;
				rresp_q <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// Reserved upper bits are never stored, so they read back as zero.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			format_q <= FORMAT_RESET;
			mask_q <= MASK_RESET;
		end else begin
			if (wr_format) begin
				format_q <= format_merge[FMT_WIDTH-1:0];
			end
			if (wr_mask) begin
				mask_q <= mask_merge;
			end
		end
	end

	// A word written while the previous one is still crossing is dropped and flagged; set wins over clear.
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			last_word_q <= 32'h00000000;
			overrun_q <= 1'b0;
			req_q <= 1'b0;
			payload_q <= '0;
			ack_s1_q <= 1'b0;
			ack_s2_q <= 1'b0;
		end else begin
			ack_s1_q <= ser_ack;
			ack_s2_q <= ack_s1_q;
			if (buf_accept && busy) begin
				overrun_q <= 1'b1;
			end else if (wr_status && wstrb_q[0] && wdata_q[POS_OVERRUN]) begin
				overrun_q <= 1'b0;
			end
			if (buf_accept && !busy) begin
				last_word_q <= source_word;
				payload_q <= {format_q[POS_SLOT +: 4], format_q[POS_DLY +: 2], fmt.result};
				req_q <= ~req_q;
			end
		end
	end

	slot_serializer u_serializer (
		.tx_bit_clock(tx_bit_clock),
		.resetn(resetn),
		.tx_frame_sync(tx_frame_sync),
		.req_toggle(req_q),
		.payload(payload_q),
		.ack_toggle(ser_ack),
		.serial_data_pin_o(serial_data_pin_o),
		.serial_data_pin_oe(serial_data_pin_oe)
	);
endmodule : audio_tx_bitstream_formatter

//--- test/tx_fmt_props.sv
module tx_fmt_props
	import tx_fmt_pkg::*;
(
	input wire logic mclk,
	input wire logic resetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic tx_bit_clock,
	input wire logic tx_frame_sync,
	input wire logic serial_data_pin_o,
	input wire logic serial_data_pin_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	// A slot restarted by a new frame sync with delay 0 would be counted as one long slot.
	logic [5:0] run_q;
	logic [5:0] run_d;
	assign run_d = serial_data_pin_oe ? run_q + 6'h01 : 6'h00;
	always_ff @(posedge tx_bit_clock or negedge resetn) begin
		if (!resetn) begin
			run_q <= 6'h00;
		end else begin
			run_q <= run_d;
		end
	end
	write_answer_a: assert property (@(posedge mclk) disable iff (!resetn)
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write got no response");
	write_block_a: assert property (@(posedge mclk) disable iff (!resetn)
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while response pending");
	write_okay_a: assert property (@(posedge mclk) disable iff (!resetn)
		s_axi_bvalid |-> s_axi_bresp == RESP_OKAY) else $error("write response not okay");
	read_answer_a: assert property (@(posedge mclk) disable iff (!resetn)
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read got no data");
	read_block_a: assert property (@(posedge mclk) disable iff (!resetn)
		s_axi_rvalid |-> !s_axi_arready) else $error("read taken while data pending");
	slot_start_a: assert property (@(posedge tx_bit_clock) disable iff (!resetn)
		$rose(serial_data_pin_oe) |-> $past(tx_frame_sync) || $past(tx_frame_sync, 2) || $past(tx_frame_sync, 3))
		else $error("slot started without frame sync");
	pin_idle_a: assert property (@(posedge tx_bit_clock) disable iff (!resetn)
		!serial_data_pin_oe |-> !serial_data_pin_o) else $error("pin not low outside slot");
	slot_length_a: assert property (@(posedge tx_bit_clock) disable iff (!resetn)
		$fell(serial_data_pin_oe) |-> !run_q[0] && run_q >= 6'h02 && run_q <= 6'h20) else $error("bad slot length");
endmodule : tx_fmt_props

bind audio_tx_bitstream_formatter tx_fmt_props u_props (.mclk, .resetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.tx_bit_clock, .tx_frame_sync, .serial_data_pin_o, .serial_data_pin_oe);

//--- test/tx_codec_model.sv
module tx_codec_model (
	input wire logic tx_bit_clock,
	input wire logic serial_data_pin_o,
	input wire logic serial_data_pin_oe,
	output logic tx_frame_sync
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] word;
	int nbits;
	int lat;
	event got;
	initial tx_frame_sync = 1'b0;
	// Bits are taken on the falling edge, half a cycle after launch, as a real receiver does.
	task automatic frame();
		int n;
		word = 32'h0;
		nbits = 0;
		lat = 0;
		@(posedge tx_bit_clock);
		tx_frame_sync <= 1'b1;
		@(posedge tx_bit_clock);
		tx_frame_sync <= 1'b0;
		for (n = 2; n < 80; n++) begin
			@(negedge tx_bit_clock);
			if (serial_data_pin_oe) begin
				if (nbits == 0) lat = n;
				word[nbits] = serial_data_pin_o;
				nbits++;
			end else if (nbits != 0) break;
		end
		->got;
	endtask : frame
endmodule : tx_codec_model

//--- test/tb_top.sv
module tb_top
	import tx_fmt_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk, tx_bit_clock, tx_frame_sync;
	logic resetn = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0, bulk_data_port_wr = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, bulk_data_port_data = 32'h0, s_axi_rdata;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic serial_data_pin_o, serial_data_pin_oe;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int failures = 0, cmp_count = 0, seed = 40;
	logic [45:0] exp_q[$];
	logic [45:0] e;
	audio_tx_bitstream_formatter i_dut (.mclk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .bulk_data_port_wr,
		.bulk_data_port_data, .tx_bit_clock, .tx_frame_sync, .serial_data_pin_o, .serial_data_pin_oe);
	tx_codec_model i_codec (.tx_bit_clock, .serial_data_pin_o, .serial_data_pin_oe, .tx_frame_sync);
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	initial begin
		tx_bit_clock = 1'b0;
		#3;
		forever #15 tx_bit_clock = ~tx_bit_clock;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] x);
		cmp_count++;
		if (seen !== x) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, x, seen);
		end
	endtask : chk
	task automatic finish_test();
		$display("comparisons %0d failures %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : finish_test
	task automatic tmo(input int n);
		if (n >= 64) begin
			failures++;
			$display("mismatch wait_limit expected answer seen none");
			finish_test();
		end
	endtask : tmo
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		tmo(n);
		chk("write_resp", 32'(s_axi_bresp), 32'(RESP_OKAY));
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		int n;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 64; n++) begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		s_axi_rready <= 1'b0;
		tmo(n);
		chk("read_resp", 32'(s_axi_rresp), 32'(RESP_OKAY));
	endtask : rd
	task automatic rdc(input logic [3:0] a, input logic [31:0] x);
		logic [31:0] v;
		rd(a, v);
		chk("register", v, x);
	endtask : rdc
	task automatic dport(input logic [31:0] d);
		@(posedge mclk);
		bulk_data_port_wr <= 1'b1;
		bulk_data_port_data <= d;
		@(posedge mclk);
		bulk_data_port_wr <= 1'b0;
	endtask : dport
	// Waits for the word to finish crossing, so a following write is not lost as an overrun.
	task automatic idle();
		int n;
		logic [31:0] s;
		s = 32'h1;
		for (n = 0; n < 64 && s[POS_BUSY]; n++) rd(ADDR_STATUS, s);
		tmo(n);
	endtask : idle
	function automatic logic [31:0] shaped(input logic [31:0] d, input logic [31:0] m, input logic [17:0] f);
		logic [31:0] w;
		logic p;
		p = (f[14:13] == PAD_ONE) | ((f[14:13] == PAD_COPY) & d[f[12:8]]);
		w = (d & m) | (~m & {32{p}});
		w = (w >> (4 * f[2:0])) | (w << (32 - 4 * f[2:0]));
		if (f[15]) w = {<<{w}};
		return w & ~(32'hffffffff << (2 * (f[7:4] + 1)));
	endfunction : shaped
	always @(i_codec.got) begin
		e = exp_q.pop_front();
		chk("slot_word", i_codec.word, e[31:0]);
		chk("slot_bits", 32'(i_codec.nbits), 32'(e[39:32]));
		chk("data_delay", 32'(i_codec.lat), 32'(e[45:40]));
	end
	initial begin
		logic [31:0] d, m, s;
		logic [17:0] f;
		repeat (16) @(posedge mclk);
		resetn <= 1'b1;
		rdc(ADDR_FORMAT, 32'h0);
		rdc(ADDR_MASK, MASK_RESET);
		wr(ADDR_FORMAT, 32'hffffffff);
		rdc(ADDR_FORMAT, 32'h0003ffff);
		$display("register test done");
		for (int i = 0; i < 8; i++) begin
			d = $random(seed);
			m = $random(seed);
			s = $random(seed);
			f = {2'(i % 3), i[1], 2'(i % 3), s[12:8], 4'(3 + 2 * (i % 7)), i[0], 3'(i)};
			wr(ADDR_FORMAT, {14'h0, f});
			rdc(ADDR_FORMAT, {14'h0, f});
			wr(ADDR_MASK, m);
			if (f[3]) wr(ADDR_BUFFER, d);
			else dport(d);
			idle();
			if (f[3]) dport(~d);
			else wr(ADDR_BUFFER, ~d);
			idle();
			rdc(ADDR_BUFFER, d);
			exp_q.push_back({6'(i % 3 + 2), 8'(2 * (f[7:4] + 1)), shaped(d, m, f)});
			i_codec.frame();
			$display("frame test %0d done", i);
		end
		repeat (4) @(posedge mclk);
		finish_test();
	end
endmodule : tb_top
